// ---- design/eic_ext_irq.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - polarity bit per input, 0 active low, 1 active high; b bit 7, a bit 3.
// - timer control edge select bit: 1 edge sensitive, 0 level sensitive.
// - input b pin select field chooses port 0 pin by its code, 000 to 111.
// - input a pin select in bits 2..0 chooses port 0 pin index.
// - pin monitoring is a passive tap, independent of the crossbar routing.
// - a pin whose skip bit is 1 gets no peripheral routed by the crossbar.
// - pending flags appear in timer control at bit 1 (a) and bit 3 (b).
// - edge mode pending flag clears when the processor vectors to its handler.
// - level mode pending flag follows the input's active level.
module eic_ext_irq
    import eic_pkg::*;
#(
    parameter int PINS = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [PINS-1:0] port0_pin,
    input wire eic_pair_t irq_edge_select,
    input wire eic_pair_t irq_vector_ack,
    output eic_pair_t irq_pending,
    output logic [7:0] timer_control_pend_bits,
    input wire logic [PINS-1:0] port0_skip_reg,
    input wire logic [PINS-1:0] crossbar_route_req,
    output logic [PINS-1:0] crossbar_route_grant
);

    eic_cfg_t cfg_q, cfg_d;
    logic [7:0] rdata_q, rdata_d;
    logic [PINS-1:0] sync1_q, sync2_q, sync3_q, stable_q;
    logic [PINS-1:0] sync1_d, sync2_d, sync3_d, stable_d;
    eic_pair_t prev_act_q, prev_act_d, pend_q, pend_d;
    eic_pair_t act, rise;

    // selected pin level turned into an active flag by the polarity bit
    // the select is three bits wide, so only the low eight pins of a wider port are reachable
    function automatic logic active_of(input logic [PINS-1:0] pins,
                                       input logic [EIC_SEL_W-1:0] sel,
                                       input logic pol);
        active_of = (pins[sel] == pol);
    endfunction : active_of

    // configuration register and read data next values
    // a read in the cycle of a write returns the old byte, since rdata samples cfg_q
    always_comb begin
        cfg_d = cfg_q;
        rdata_d = EIC_ZERO_BYTE;
        if (sfr_wr && sfr_addr == EIC_CFG_ADDR) begin
            cfg_d = eic_cfg_t'(sfr_wdata);
        end
        if (sfr_rd && sfr_addr == EIC_CFG_ADDR) begin
            rdata_d = cfg_q; // other addresses read as zero from this block
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_q <= eic_cfg_t'(EIC_CFG_RESET);
            rdata_q <= EIC_ZERO_BYTE;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;

    // three-stage synchroniser; a change is accepted once stages two and three agree
    always_comb begin
        sync1_d = port0_pin; // passive tap, pin drivers untouched
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        stable_d = stable_q;
        for (int i = 0; i < PINS; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                stable_d[i] = sync3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            // port pins idle high on their pull-ups; resetting to zero would make an
            // active-low input look asserted and fake an edge just after reset
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            stable_q <= '1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            stable_q <= stable_d;
        end
    end

    // pin selection, polarity and transition detection
    always_comb begin
        act.a = active_of(stable_q, cfg_q.irq_a_pin_select, cfg_q.irq_a_polarity);
        act.b = active_of(stable_q, cfg_q.irq_b_pin_select, cfg_q.irq_b_polarity);
        rise.a = act.a && !prev_act_q.a;
        rise.b = act.b && !prev_act_q.b;
    end

    // pending flags; in edge mode a new edge beats a vector acknowledge in the same cycle
    // level mode relies on the source holding the request until it is taken
    // edges come from the filtered level, so a pin glitch of one cycle is ignored
    always_comb begin
        prev_act_d = act;
        pend_d.a = (irq_edge_select.a == EIC_EDGE) ?
                   (rise.a || (pend_q.a && !irq_vector_ack.a)) : act.a;
        pend_d.b = (irq_edge_select.b == EIC_EDGE) ?
                   (rise.b || (pend_q.b && !irq_vector_ack.b)) : act.b;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prev_act_q <= '0;
            pend_q <= '0;
        end else begin
            prev_act_q <= prev_act_d;
            pend_q <= pend_d;
        end
    end

    assign irq_pending = pend_q;

    // flags placed at their timer control positions for merging by the core
    always_comb begin
        timer_control_pend_bits = EIC_ZERO_BYTE;
        timer_control_pend_bits[EIC_A_PEND_BIT] = pend_q.a;
        timer_control_pend_bits[EIC_B_PEND_BIT] = pend_q.b;
    end

    // skipped pins are never handed to a peripheral, leaving them to the interrupt tap
    assign crossbar_route_grant = crossbar_route_req & ~port0_skip_reg;

    // checks run only out of reset; the synchronous reset loads every flop they watch with its reset value
    // and disable iff drops any attempt that spans a reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence a_rise_s;
        !prev_act_q.a ##0 act.a;
    endsequence
    sequence b_rise_s;
        !prev_act_q.b ##0 act.b;
    endsequence
    // vector acknowledge taken while the input is in edge mode
    sequence a_ack_s;
        irq_edge_select.a ##0 irq_vector_ack.a;
    endsequence
    sequence b_ack_s;
        irq_edge_select.b ##0 irq_vector_ack.b;
    endsequence

    edge_set_a_a: assert property (
        irq_edge_select.a ##0 a_rise_s |=> pend_q.a)
        else $error("edge on input a did not set pending");
    edge_set_b_a: assert property (
        irq_edge_select.b ##0 b_rise_s |=> pend_q.b)
        else $error("edge on input b did not set pending");
    vector_clear_a: assert property (
        irq_edge_select.a && irq_vector_ack.a && !rise.a |=> !pend_q.a)
        else $error("vector acknowledge did not clear pending a");
    level_follow_a: assert property (
        !irq_edge_select.b |=> pend_q.b == $past(act.b))
        else $error("level pending b does not follow input");
    polarity_sel_a: assert property (
        act.a == (stable_q[cfg_q.irq_a_pin_select] == cfg_q.irq_a_polarity))
        else $error("input a active level wrong");
    cfg_write_a: assert property (
        sfr_wr && sfr_addr == EIC_CFG_ADDR |=> cfg_q == $past(sfr_wdata))
        else $error("configuration write lost");
    cfg_read_a: assert property (
        sfr_rd && sfr_addr == EIC_CFG_ADDR && !sfr_wr |=> sfr_rdata == $past(cfg_q))
        else $error("configuration read wrong");
    skip_block_a: assert property (
        (crossbar_route_grant & port0_skip_reg) == '0)
        else $error("skipped pin routed to a peripheral");
    pend_map_a: assert property (
        timer_control_pend_bits == {4'h0, pend_q.b, 1'b0, pend_q.a, 1'b0})
        else $error("pending bits misplaced");
    sync_settle_a: assert property (
        sync2_q[0] == sync3_q[0] |=> stable_q[0] == $past(sync3_q[0]))
        else $error("synchroniser did not settle");

    // an edge that meets a vector acknowledge must still leave the flag set
    set_wins_a_a: assert property (
        a_ack_s ##0 a_rise_s |=> pend_q.a)
        else $error("edge lost against acknowledge on input a");
    vector_clear_b_a: assert property (
        b_ack_s ##0 !rise.b |=> !pend_q.b)
        else $error("vector acknowledge did not clear pending b");
    level_pend_a_a: assert property (
        !irq_edge_select.a |=> pend_q.a == $past(act.a))
        else $error("level pending a does not follow input");
    level_ack_ignore_a: assert property (
        !irq_edge_select.a && irq_vector_ack.a && act.a |=> pend_q.a)
        else $error("acknowledge disturbed level pending a");
    // a half-settled pin must not move the accepted level
    stable_hold_a: assert property (
        sync2_q[0] != sync3_q[0] |=> $stable(stable_q[0]))
        else $error("synchroniser accepted an unsettled pin");
    cfg_hold_a: assert property (
        !(sfr_wr && sfr_addr == EIC_CFG_ADDR) |=> $stable(cfg_q))
        else $error("configuration changed without a write");
    rdata_idle_a: assert property (
        !sfr_rd |=> sfr_rdata == EIC_ZERO_BYTE)
        else $error("read data not cleared after read");
    // routing on pins that are not skipped passes untouched by the tap
    grant_pass_a: assert property (
        (crossbar_route_grant | port0_skip_reg) == (crossbar_route_req | port0_skip_reg))
        else $error("crossbar routing disturbed on an unskipped pin");

endmodule : eic_ext_irq

// ---- pkg/eic_pkg.sv ----
package eic_pkg;
    // special function register address and reset value of the configuration byte
    localparam logic [7:0] EIC_CFG_ADDR = 8'he4;
    localparam logic [7:0] EIC_CFG_RESET = 8'h01;
    // field positions inside the configuration byte
    localparam int EIC_B_POL_BIT = 7;
    localparam int EIC_B_SEL_LSB = 4;
    localparam int EIC_A_POL_BIT = 3;
    localparam int EIC_A_SEL_LSB = 0;
    localparam int EIC_SEL_W = 3;
    // pending flag positions inside the timer control register
    localparam int EIC_A_PEND_BIT = 1;
    localparam int EIC_B_PEND_BIT = 3;
    // sensitivity encodings of the timer control edge select bits
    localparam logic EIC_EDGE = 1'b1;
    localparam logic EIC_LEVEL = 1'b0;
    // polarity encodings
    localparam logic EIC_ACT_HIGH = 1'b1;
    localparam logic EIC_ACT_LOW = 1'b0;
    localparam logic [7:0] EIC_ZERO_BYTE = 8'h00;

    // configuration byte, packed to match its bit layout
    typedef struct packed {
        logic irq_b_polarity;
        logic [2:0] irq_b_pin_select;
        logic irq_a_polarity;
        logic [2:0] irq_a_pin_select;
    } eic_cfg_t;

    // one bit per external request input
    typedef struct packed {
        logic b;
        logic a;
    } eic_pair_t;
endpackage : eic_pkg

// ---- tb/eic_src_model.sv ----
`timescale 1ns/1ps
module eic_src_model (
    input wire logic clk_sys,
    input wire logic req,
    input wire logic ack,
    input wire logic pol,
    input wire logic [2:0] pin_idx,
    output logic [7:0] pins
);
    logic active_q = 1'b0;
    // a request is held until the core recognises it, then dropped before the handler ends
    always @(posedge clk_sys) begin
        if (req) begin
            active_q <= 1'b1;
        end else if (ack) begin
            active_q <= 1'b0;
        end
    end
    // idle pins rest inactive, so a select change alone should not look like a request
    always_comb begin
        pins = {8{~pol}};
        pins[pin_idx] = active_q ? pol : ~pol;
    end
endmodule : eic_src_model

// ---- tb/external_interrupt_config_tb.sv ----
`timescale 1ns/1ps
module external_interrupt_config_tb;
    import eic_pkg::*;
    typedef struct {logic who; logic [2:0] sel; logic pol; logic edge_m;
        logic [7:0] timer_control_reg;} eic_row_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, timer_control_reg_bits, grant;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, req = 1'b0, pol = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [7:0] pins, skip = 8'h00, route = 8'h00;
    eic_pair_t edge_sel = 2'b00, ack = 2'b00, pend, expd;
    int mismatches = 0, num_checks = 0;
    eic_row_t row;
    // rows alternate inputs so every select code and both polarities and modes are hit;
    // the last field is the timer control byte that the raised flag should give
    eic_row_t rows [8] = '{'{0, 0, 0, 1, 8'h02}, '{1, 1, 1, 0, 8'h08},
        '{0, 2, 1, 1, 8'h02}, '{1, 3, 0, 0, 8'h08}, '{0, 4, 0, 0, 8'h02},
        '{1, 5, 1, 1, 8'h08}, '{0, 6, 1, 0, 8'h02}, '{1, 7, 0, 1, 8'h08}};
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    eic_ext_irq DUT (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .port0_pin(pins), .irq_edge_select(edge_sel), .irq_vector_ack(ack),
        .irq_pending(pend), .timer_control_pend_bits(timer_control_reg_bits), .port0_skip_reg(skip),
        .crossbar_route_req(route), .crossbar_route_grant(grant));
    eic_src_model src (.clk_sys(clk_sys), .req(req), .ack(|ack), .pol(pol), .pin_idx(idx),
        .pins(pins));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic sfr_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = ~wr;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        if (!wr) chk(sfr_rdata, d);
    endtask : sfr_access
    // bounded wait on the pending pair; running out is a mismatch and ends the run
    task automatic wait_pend(input eic_pair_t exp);
        int n;
        n = 0;
        while (pend !== exp && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        chk({6'h00, pend}, {6'h00, exp});
        if (pend !== exp) begin
            report_and_stop();
        end
    endtask : wait_pend
    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        chk(sfr_rdata, EIC_ZERO_BYTE);
        sfr_access(1'b0, EIC_CFG_ADDR, EIC_CFG_RESET);
        sfr_access(1'b1, EIC_CFG_ADDR, 8'h5a);
        sfr_access(1'b0, EIC_CFG_ADDR, 8'h5a);
        sfr_access(1'b0, 8'he5, EIC_ZERO_BYTE);
        route = 8'hff;
        skip = 8'ha5;
        @(negedge clk_sys);
        chk(grant, 8'h5a);
        foreach (rows[i]) begin
            row = rows[i];
            pol = row.pol;
            idx = row.sel;
            edge_sel = {row.edge_m, row.edge_m};
            sfr_access(1'b1, EIC_CFG_ADDR, row.who ? {row.pol, row.sel, row.pol, ~row.sel}
                : {row.pol, ~row.sel, row.pol, row.sel});
            repeat (8) @(negedge clk_sys);
            ack = 2'b11;
            @(negedge clk_sys);
            ack = 2'b00;
            wait_pend(2'b00);
            expd = row.who ? 2'b10 : 2'b01;
            req = 1'b1;
            @(negedge clk_sys);
            req = 1'b0;
            wait_pend(expd);
            chk(timer_control_reg_bits, row.timer_control_reg);
            repeat (5) @(negedge clk_sys);
            chk({6'h00, pend}, {6'h00, expd});
            ack = expd;
            @(negedge clk_sys);
            ack = 2'b00;
            chk({6'h00, pend}, row.edge_m ? 8'h00 : {6'h00, expd});
            wait_pend(2'b00);
        end
        chk(grant, 8'h5a);
        // awkward case: the edge lands in the cycle of a vector acknowledge; the set wins
        idx = 3'h0;
        req = 1'b1;
        repeat (4) @(negedge clk_sys);
        ack = 2'b01;
        repeat (2) @(negedge clk_sys);
        req = 1'b0;
        ack = 2'b00;
        chk({6'h00, pend}, 8'h01);
        @(negedge clk_sys);
        ack = 2'b01;
        @(negedge clk_sys);
        ack = 2'b00;
        chk({6'h00, pend}, 8'h00);
        repeat (6) @(negedge clk_sys);
        // mid-run reset with idle pins: the default byte returns and no edge is faked
        reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        chk(sfr_rdata, EIC_ZERO_BYTE);
        repeat (8) @(negedge clk_sys);
        chk({6'h00, pend}, 8'h00);
        chk(timer_control_reg_bits, EIC_ZERO_BYTE);
        sfr_access(1'b0, EIC_CFG_ADDR, EIC_CFG_RESET);
        report_and_stop();
    end
endmodule : external_interrupt_config_tb
